// [rtl/oad_detect.sv]
// orientation and activity detector with an axi4-lite register slave.
// assumes sample inputs come from logic on clk_sys, with sample_valid
// a one-cycle pulse per set of axes at the output sample rate.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module oad_detect
   import oad_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // axis samples
   input wire logic sample_valid,
   input wire logic signed [7:0] sample_x,
   input wire logic signed [7:0] sample_y,
   input wire logic signed [7:0] sample_z,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // state and interrupt
   output logic [2:0] orientation_state,
   output logic active_state,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////
   // registers written by software
   logic [1:0] ctrl_ff; // engine enables
   logic [7:0] rot_qual_ff; // orientation qualify count
   logic [7:0] wake_qualify_count_ff;
   logic [7:0] sleep_qualify_count_ff;
   logic [7:0] wake_change_threshold_ff;
   logic [7:0] sleep_change_threshold_ff;
   logic [7:0] tilt_thr_ff; // orientation angle threshold
   logic [3:0] rotation_hysteresis_setting_ff;
   logic [2:0] axis_mask_ff; // x, y, z axis state masks
   logic [2:0] int_en_ff; // interrupt enables
   logic [2:0] int_stat_ff; // sticky events

   // bus state
   logic aw_got_ff; // write address captured
   logic w_got_ff; // write data captured
   logic [7:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_go; // both halves present, commit this cycle
   logic ar_take; // read address accepted this cycle
   logic wr_hit; // write address is a writable offset

   // detector state
   oad_ori_t ori_ff; // accepted orientation
   oad_ori_t pend_ff; // candidate being qualified
   oad_ori_t cand; // candidate from this sample
   logic active_ff; // activity state
   logic [2:0] wake_axes_ff; // axes that caused the last wake
   logic signed [7:0] prev_ff [3]; // last sample set
   logic [3:0] pre_ff; // sleep step prescaler
   logic signed [7:0] smp [3]; // current sample set
   logic [2:0] over_wake; // axis change above wake threshold
   logic [2:0] under_sleep; // axis change below sleep threshold
   logic rot_fire, wake_fire, sleep_fire;
   logic rot_hold, wake_hold, sleep_hold;
   logic sleep_step;
   logic [2:0] evt; // events this cycle

   ////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data taken in either order
   assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
   assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // capture write address and data
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_got_ff <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end else if (wr_go) begin
            w_got_ff <= 1'b0;
         end
      end
   end

   // decode of the write address
   always_comb begin
      unique case (aw_addr_ff)
         OFS_CTRL, OFS_ROT_QUAL, OFS_WAKE_QUAL, OFS_SLEEP_QUAL,
         OFS_WAKE_THR, OFS_SLEEP_THR, OFS_TILT_THR, OFS_HYST,
         OFS_MASK, OFS_INT_CLR, OFS_INT_EN: wr_hit = 1'b1;
         default: wr_hit = 1'b0; // read-only or unmapped
      endcase
   end

   // write response, slverr for unmapped or read-only offsets
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'b00;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // configuration registers; only byte lane 0 carries data
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctrl_ff <= RST_CTRL;
         rot_qual_ff <= RST_ROT_QUAL;
         wake_qualify_count_ff <= RST_WAKE_QUAL;
         sleep_qualify_count_ff <= RST_SLEEP_QUAL;
         wake_change_threshold_ff <= RST_WAKE_THR;
         sleep_change_threshold_ff <= RST_SLEEP_THR;
         tilt_thr_ff <= RST_TILT_THR;
         rotation_hysteresis_setting_ff <= RST_HYST;
         axis_mask_ff <= RST_MASK;
         int_en_ff <= RST_INT_EN;
      end else if (wr_go & w_strb_ff[0]) begin
         unique case (aw_addr_ff)
            OFS_CTRL: ctrl_ff <= w_data_ff[1:0];
            OFS_ROT_QUAL: rot_qual_ff <= w_data_ff[7:0];
            OFS_WAKE_QUAL: wake_qualify_count_ff <= w_data_ff[7:0];
            OFS_SLEEP_QUAL: sleep_qualify_count_ff <= w_data_ff[7:0];
            OFS_WAKE_THR: wake_change_threshold_ff <= w_data_ff[7:0];
            OFS_SLEEP_THR: sleep_change_threshold_ff <= w_data_ff[7:0];
            OFS_TILT_THR: tilt_thr_ff <= w_data_ff[7:0];
            OFS_HYST: rotation_hysteresis_setting_ff <= w_data_ff[3:0];
            OFS_MASK: axis_mask_ff <= w_data_ff[2:0];
            OFS_INT_EN: int_en_ff <= w_data_ff[2:0];
            default: begin
               // clear register and unmapped offsets store nothing
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite read channel: one read in flight, answer next cycle
   assign s_axi_arready = ~rvalid_ff;
   assign ar_take = s_axi_arvalid & ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // read mux; unused high bits read as zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= 2'b00;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= 2'b00;
         unique case (s_axi_araddr)
            OFS_CTRL: rdata_ff <= {30'h0, ctrl_ff};
            OFS_ROT_QUAL: rdata_ff <= {24'h0, rot_qual_ff};
            OFS_WAKE_QUAL: rdata_ff <= {24'h0, wake_qualify_count_ff};
            OFS_SLEEP_QUAL: rdata_ff <= {24'h0, sleep_qualify_count_ff};
            OFS_WAKE_THR: rdata_ff <= {24'h0, wake_change_threshold_ff};
            OFS_SLEEP_THR: rdata_ff <= {24'h0, sleep_change_threshold_ff};
            OFS_TILT_THR: rdata_ff <= {24'h0, tilt_thr_ff};
            OFS_HYST: rdata_ff <= {28'h0, rotation_hysteresis_setting_ff};
            OFS_MASK: rdata_ff <= {29'h0, axis_mask_ff};
            OFS_STATUS: rdata_ff <= {25'h0, wake_axes_ff, active_ff, ori_ff};
            OFS_INT_STAT: rdata_ff <= {29'h0, int_stat_ff};
            OFS_INT_EN: rdata_ff <= {29'h0, int_en_ff};
            OFS_INT_CLR: rdata_ff <= 32'h0000_0000; // write only
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= 2'b10; // unmapped
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // orientation candidate from one sample set
   always_comb begin
      logic signed [9:0] ax4, ay4, hi, lo;
      logic [16:0] r2; // in-plane magnitude squared
      logic [20:0] r2_64, t2;
      ax4 = {sample_x, 2'b00}; // 64 counts per g, like the limits
      ay4 = {sample_y, 2'b00};
      hi = signed'({3'b000, HYST_HI[rotation_hysteresis_setting_ff]});
      lo = signed'({3'b000, HYST_LO[rotation_hysteresis_setting_ff]});
      r2 = 17'(unsigned'(16'(sample_x * sample_x)))
         + 17'(unsigned'(16'(sample_y * sample_y)));
      r2_64 = {r2, 4'h0};
      t2 = {5'h00, 16'(tilt_thr_ff * tilt_thr_ff)};
      cand = ori_ff; // between limits the state stays put
      if (r2_64 <= t2) begin
         // too flat to tell a screen direction
         cand = sample_z[7] ? ORI_FACE_DOWN : ORI_FACE_UP;
      end else if (ay4 > hi && ax4 > -lo && ax4 < lo) begin
         cand = ORI_ROT_0;
      end else if (ax4 > hi && ay4 > -lo && ay4 < lo) begin
         cand = ORI_ROT_90;
      end else if (ay4 < -hi && ax4 > -lo && ax4 < lo) begin
         cand = ORI_ROT_180;
      end else if (ax4 < -hi && ay4 > -lo && ay4 < lo) begin
         cand = ORI_ROT_270;
      end else if (ori_ff == ORI_FACE_UP || ori_ff == ORI_FACE_DOWN) begin
         // tilted but in no rotation window: leave face state
         cand = ori_ff;
      end
   end

   // candidate must match the pending one and differ from the state
   assign rot_hold = ctrl_ff[CTRL_ROT_EN] & (cand == pend_ff)
      & (cand != ori_ff);

   oad_qualify u_rot_qual (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sample(sample_valid),
      .step(1'b1),
      .hold(rot_hold),
      .limit(rot_qual_ff),
      .fire(rot_fire)
   );

   // orientation state and pending candidate
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ori_ff <= ORI_FACE_UP;
         pend_ff <= ORI_FACE_UP;
      end else if (sample_valid) begin
         pend_ff <= cand;
         if (rot_fire) begin
            ori_ff <= cand;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-axis change in acceleration against both thresholds
   assign smp[0] = sample_x;
   assign smp[1] = sample_y;
   assign smp[2] = sample_z;

   generate
      for (genvar i = 0; i < 3; i++) begin : g_axis
         logic signed [8:0] diff;
         logic [8:0] mag;
         logic [10:0] mag4; // scaled like the thresholds
         assign diff = 9'(smp[i]) - 9'(prev_ff[i]);
         assign mag = diff[8] ? 9'(-diff) : diff;
         assign mag4 = {mag, 2'b00};
         // bit 2 of the masks is x, bit 0 is z
         assign over_wake[2 - i] = mag4 > {3'h0, wake_change_threshold_ff};
         assign under_sleep[2 - i] =
            mag4 < {3'h0, sleep_change_threshold_ff};
      end
   endgenerate

   // previous sample set; the first delta after reset is from zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         prev_ff <= '{8'sh00, 8'sh00, 8'sh00};
      end else if (sample_valid) begin
         prev_ff <= smp;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // activity engine
   assign wake_hold = ctrl_ff[CTRL_ACT_EN] & ~active_ff
      & (|over_wake);
   assign sleep_hold = ctrl_ff[CTRL_ACT_EN] & active_ff
      & (&under_sleep);
   // one sleep step per sixteen held samples
   assign sleep_step = (pre_ff == SLEEP_PRESCALE_LAST);

   // sleep prescaler, restarted whenever the sleep candidate lapses
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pre_ff <= 4'h0;
      end else if (sample_valid) begin
         pre_ff <= sleep_hold ? pre_ff + 4'h1 : 4'h0;
      end
   end

   oad_qualify u_wake_qual (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sample(sample_valid),
      .step(1'b1), // one count per sample
      .hold(wake_hold),
      .limit(wake_qualify_count_ff),
      .fire(wake_fire)
   );

   oad_qualify u_sleep_qual (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sample(sample_valid),
      .step(sleep_step),
      .hold(sleep_hold),
      .limit(sleep_qualify_count_ff),
      .fire(sleep_fire)
   );

   // activity state and the axes that woke it
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         active_ff <= 1'b0;
         wake_axes_ff <= 3'h0;
      end else if (wake_fire) begin
         active_ff <= 1'b1;
         wake_axes_ff <= over_wake;
      end else if (sleep_fire) begin
         active_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // events; activity events only for unmasked axes
   assign evt[EVT_ROT] = rot_fire;
   assign evt[EVT_WAKE] = wake_fire & |(over_wake & axis_mask_ff);
   assign evt[EVT_SLEEP] = sleep_fire & (|axis_mask_ff);

   // sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         int_stat_ff <= 3'h0;
      end else if (wr_go & w_strb_ff[0] & (aw_addr_ff == OFS_INT_CLR)) begin
         int_stat_ff <= (int_stat_ff & ~w_data_ff[2:0]) | evt;
      end else begin
         int_stat_ff <= int_stat_ff | evt;
      end
   end

   // level interrupt while any enabled event is pending
   assign irq = |(int_stat_ff & int_en_ff);
   assign orientation_state = ori_ff;
   assign active_state = active_ff;

endmodule

// [rtl/oad_pkg.sv]
// package for the orientation and activity detector: register map,
// reset values, field positions, state codes and hysteresis limits.
// assumes samples arrive as 8-bit signed counts at 16 counts per g.
package oad_pkg;

   ////////////////////////////////////////////////////////////////////
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OFS_CTRL = 8'h00; // block enables
   localparam logic [7:0] OFS_ROT_QUAL = 8'h04; // orientation qualify
   localparam logic [7:0] OFS_WAKE_QUAL = 8'h08; // wake qualify count
   localparam logic [7:0] OFS_SLEEP_QUAL = 8'h0C; // sleep qualify count
   localparam logic [7:0] OFS_WAKE_THR = 8'h10; // wake change threshold
   localparam logic [7:0] OFS_SLEEP_THR = 8'h14; // sleep change threshold
   localparam logic [7:0] OFS_TILT_THR = 8'h18; // orientation angle thr
   localparam logic [7:0] OFS_HYST = 8'h1C; // rotation hysteresis
   localparam logic [7:0] OFS_MASK = 8'h20; // axis state mask
   localparam logic [7:0] OFS_STATUS = 8'h24; // live state, read only
   localparam logic [7:0] OFS_INT_STAT = 8'h28; // sticky events, ro
   localparam logic [7:0] OFS_INT_CLR = 8'h2C; // write one to clear
   localparam logic [7:0] OFS_INT_EN = 8'h30; // interrupt enables

   ////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [1:0] RST_CTRL = 2'h3;
   localparam logic [7:0] RST_ROT_QUAL = 8'h00;
   localparam logic [7:0] RST_WAKE_QUAL = 8'h00;
   localparam logic [7:0] RST_SLEEP_QUAL = 8'h00;
   localparam logic [7:0] RST_WAKE_THR = 8'h20; // 0.5 g
   localparam logic [7:0] RST_SLEEP_THR = 8'h60; // 1.5 g
   localparam logic [7:0] RST_TILT_THR = 8'h1C; // about 26 degrees
   localparam logic [3:0] RST_HYST = 4'h8; // +/-15 degrees
   localparam logic [2:0] RST_MASK = 3'h7;
   localparam logic [2:0] RST_INT_EN = 3'h0;

   ////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL_ROT_EN = 0; // orientation engine enable
   localparam int CTRL_ACT_EN = 1; // activity engine enable
   localparam int MASK_X = 2; // x axis state mask
   localparam int MASK_Y = 1; // y axis state mask
   localparam int MASK_Z = 0; // z axis state mask
   localparam int EVT_ROT = 0; // orientation changed
   localparam int EVT_WAKE = 1; // went active
   localparam int EVT_SLEEP = 2; // went inactive
   localparam int STAT_ACTIVE = 3; // status bit: active state
   localparam logic [3:0] SLEEP_PRESCALE_LAST = 4'hF; // 16 samples

   ////////////////////////////////////////////////////////////////////
   // orientation states
   typedef enum logic [2:0] {
      ORI_FACE_UP = 3'b000,
      ORI_FACE_DOWN = 3'b001,
      ORI_ROT_0 = 3'b010,
      ORI_ROT_90 = 3'b011,
      ORI_ROT_180 = 3'b100,
      ORI_ROT_270 = 3'b101
   } oad_ori_t;

   ////////////////////////////////////////////////////////////////////
   // acceptance limits per hysteresis code, in 64 counts per g
   // (sample times four). code 8 gives 0.866 g and 0.5 g.
   localparam logic [6:0] HYST_HI [16] = '{
      7'h30, 7'h31, 7'h32, 7'h34, 7'h34, 7'h35, 7'h36, 7'h37,
      7'h37, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3D, 7'h3E};
   localparam logic [6:0] HYST_LO [16] = '{
      7'h2B, 7'h29, 7'h27, 7'h26, 7'h25, 7'h24, 7'h22, 7'h21,
      7'h20, 7'h1E, 7'h1C, 7'h1A, 7'h17, 7'h15, 7'h13, 7'h11};

endpackage

// [rtl/oad_qualify.sv]
// qualify counter: a candidate must hold for a programmed number of
// steps before it fires. assumes sample is a one-cycle pulse; sample and step come
// from logic on clk_sys.
`timescale 1ns/10ps
module oad_qualify
   import oad_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // evaluation
   input wire logic sample, // a new sample set is being judged
   input wire logic step, // this sample advances the count
   input wire logic hold, // candidate still holds
   input wire logic [7:0] limit, // programmed qualify count
   // result
   output logic fire // candidate accepted this cycle
);

   logic [7:0] cnt_ff; // steps held so far
   logic [7:0] nxt_cnt;

   ////////////////////////////////////////////////////////////////////
   // accept once the count reaches the limit on a step
   assign fire = sample & hold & step & (cnt_ff >= limit);

   // next count: cleared whenever the candidate lapses
   always_comb begin
      nxt_cnt = cnt_ff;
      if (sample & ~hold) begin
         nxt_cnt = 8'h00;
      end else if (fire) begin
         nxt_cnt = 8'h00; // restart for the next change
      end else if (sample & step & (cnt_ff != 8'hFF)) begin
         nxt_cnt = cnt_ff + 8'h01; // saturates, never wraps
      end
   end

   // counter register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule

// [bench/oad_detect_assertions.sv]
// checker for the detector: relations between its ports over time.
// assumes one clk_sys domain with a synchronous low rst_b.
`timescale 1ns/10ps
module oad_detect_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // samples and bus
   input wire logic sample_valid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // outputs under watch
   input wire logic [2:0] orientation_state,
   input wire logic active_state,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // samples seen while active; saturates so it never wraps
   logic [7:0] act_smp_ff;
   always_ff @(posedge clk_sys) begin
      if (!rst_b || !active_state) begin
         act_smp_ff <= 8'h00;
      end else if (sample_valid && act_smp_ff != 8'hFF) begin
         act_smp_ff <= act_smp_ff + 8'h01;
      end
   end
   // a read is taken, then answered one cycle on
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rd_answer;
      s_axi_rvalid;
   endsequence
   AST_ORI_ON_SAMPLE: assert property (!sample_valid |=>
      $stable(orientation_state)) else $error("orientation moved");
   AST_ACT_ON_SAMPLE: assert property (!sample_valid |=>
      $stable(active_state)) else $error("activity moved");
   AST_ORI_CODE: assert property (orientation_state <= 3'h5)
      else $error("bad orientation code");
   AST_SLEEP_QUAL: assert property ($fell(active_state) |->
      $past(act_smp_ff) >= 8'h0F) else $error("sleep too early");
   AST_IRQ_CAUSE: assert property ($rose(irq) |->
      $past(sample_valid) || s_axi_bvalid)
      else $error("irq rose uncaused");
   AST_RD_ANSWER: assert property (s_rd_take |=> s_rd_answer)
      else $error("read not answered");
   AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response stuck");
endmodule
bind oad_detect oad_detect_checker i_chk (.clk_sys(clk_sys),
   .rst_b(rst_b), .sample_valid(sample_valid),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .orientation_state(orientation_state),
   .active_state(active_state), .irq(irq));

// [bench/oad_sample_src.sv]
// sample source: the front end that hands axis sets to the detector.
// assumes clk_sys is shared with the detector.
`timescale 1ns/10ps
module oad_sample_src (
   // clock
   input wire logic clk_sys,
   // axis sets toward the detector
   output logic sample_valid,
   output logic signed [7:0] sample_x,
   output logic signed [7:0] sample_y,
   output logic signed [7:0] sample_z
);
   initial begin
      sample_valid = 1'b0;
      sample_x = 8'h00;
      sample_y = 8'h00;
      sample_z = 8'h00;
   end
   // one pulse per set; data is inverted off the pulse so stale
   // values cannot pass for fresh ones
   task automatic send(input logic signed [7:0] x, y, z);
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_x <= x;
      sample_y <= y;
      sample_z <= z;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      sample_x <= ~x;
      sample_y <= ~y;
      sample_z <= ~z;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule

// [bench/oad_detect_tb.sv]
// bench for the detector: axi4-lite tasks plus sample sequences.
// assumes the checker is bound to the detector by its own file.
`timescale 1ns/10ps
module oad_detect_tb;
   import oad_pkg::*;
   logic clk_sys = 1'b0, rst_b = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, sample_valid, active_state, irq;
   logic signed [7:0] sample_x, sample_y, sample_z;
   logic [2:0] orientation_state;
   int fails = 0, samples_checked = 0;
   always #2 clk_sys = ~clk_sys;
   ///////////////////////////////////////////////////////////////////
   oad_sample_src i_src (.clk_sys(clk_sys), .sample_valid(sample_valid),
      .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z));
   // responses are always accepted at once
   oad_detect i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .sample_valid(sample_valid), .sample_x(sample_x),
      .sample_y(sample_y), .sample_z(sample_z),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(1'b1), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .orientation_state(orientation_state),
      .active_state(active_state), .irq(irq));
   task automatic chk(input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t saw %h expected %h", $time, s, e);
      end
   endtask
   // each channel is released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, ta, tw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      while (pa || pw) begin
         @(negedge clk_sys);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys);
   endtask
   // four like sets: enough to qualify with a count of two
   task automatic hold4(input logic signed [7:0] x, y, z);
      repeat (4) i_src.send(x, y, z);
   endtask
   task automatic test_done;
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   localparam logic [7:0] RA [7] = '{OFS_CTRL, OFS_WAKE_THR,
      OFS_SLEEP_THR, OFS_TILT_THR, OFS_HYST, OFS_MASK, OFS_INT_EN};
   localparam logic [7:0] RV [7] = '{8'h03, 8'h20, 8'h60, 8'h1C,
      8'h08, 8'h07, 8'h00};
   initial begin
      logic [31:0] d;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      chk(orientation_state, ORI_FACE_UP);
      for (int i = 0; i < 7; i++) begin
         rd(RA[i], d);
         chk(d, RV[i]);
      end
      // read-only and unmapped offsets answer with slverr
      wr(OFS_STATUS, 32'h1);
      chk(resp, 2'h2);
      rd(8'hFC, d);
      chk(resp, 2'h2);
      chk(d, 32'h0);
      // activity off so sample steps cannot wake the device
      wr(OFS_CTRL, 32'h1);
      chk(resp, 2'h0);
      wr(OFS_ROT_QUAL, 32'h2);
      wr(OFS_INT_EN, 32'h1);
      repeat (3) i_src.send(0, 16, 0);
      chk(orientation_state, ORI_FACE_UP);
      i_src.send(0, 16, 0);
      chk(orientation_state, ORI_ROT_0);
      chk(irq, 1);
      wr(OFS_INT_CLR, 32'h1);
      chk(irq, 0);
      // a lapse must restart the count
      repeat (2) i_src.send(16, 0, 0);
      i_src.send(0, 16, 0);
      repeat (3) i_src.send(16, 0, 0);
      chk(orientation_state, ORI_ROT_0);
      i_src.send(16, 0, 0);
      chk(orientation_state, ORI_ROT_90);
      hold4(0, 13, 0);
      chk(orientation_state, ORI_ROT_90);
      wr(OFS_HYST, 32'h0);
      hold4(0, 13, 0);
      chk(orientation_state, ORI_ROT_0);
      wr(OFS_TILT_THR, 32'h40);
      hold4(16, 0, 0);
      chk(orientation_state, ORI_FACE_UP);
      hold4(0, 0, -16);
      chk(orientation_state, ORI_FACE_DOWN);
      wr(OFS_CTRL, 32'h2);
      wr(OFS_WAKE_QUAL, 32'h1);
      wr(OFS_WAKE_THR, 32'h20);
      wr(OFS_SLEEP_THR, 32'h60);
      wr(OFS_MASK, 32'h6);
      wr(OFS_INT_CLR, 32'h7);
      wr(OFS_INT_EN, 32'h6);
      repeat (2) i_src.send(0, 0, 0);
      chk(active_state, 0);
      i_src.send(0, 0, 16);
      chk(active_state, 0);
      i_src.send(0, 0, 0);
      chk(active_state, 1);
      chk(irq, 0);
      rd(OFS_STATUS, d);
      chk(d, 32'h19);
      repeat (15) i_src.send(0, 0, 0);
      chk(active_state, 1);
      i_src.send(0, 0, 0);
      chk(active_state, 0);
      chk(irq, 1);
      rd(OFS_INT_STAT, d);
      chk(d, 32'h4);
      test_done;
   end
   initial begin
      repeat (6000) @(posedge clk_sys);
      fails++;
      test_done;
   end
endmodule
